// ==== src/cmb_device.sv ====
// message buffering device: three tx buffers, rx fifo, bus-off hold, rx error count
// assumes a protocol engine on the same clock drives the link strobes
`timescale 1ns/1ns
`default_nettype none
module cmb_device
  import cmb_pkg::*;
#(
  parameter int RX_DEPTH = CMB_RX_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  cmb_if.dev bus,
  input wire logic arb_start,
  input wire logic tx_done,
  input wire logic tx_error,
  output logic tx_valid,
  output cmb_frame_t tx_frame,
  input wire logic rx_valid,
  input wire cmb_frame_t rx_frame,
  input wire logic rx_error,
  input wire logic busoff_enter,
  output logic busoff_hold,
  output logic tx_irq,
  output logic rx_irq
);
  if (RX_DEPTH < 2 || RX_DEPTH > 7) begin : gen_depth_check
    $error("RX_DEPTH must be 2..7");
  end

  typedef struct packed {
    logic [4:0] ctl;
    logic sleep_acknowledge;
    logic init_acknowledge;
    logic hold;
    logic [7:0] rxerr;
    logic [2:0] empty;
    logic [2:0] arq;
    logic [2:0] aak;
    logic [2:0] sel;
    logic [7:0] fcode;
    logic [7:0] fmask;
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [2:0] cnt;
    logic busy;
    logic [1:0] cur;
    logic tx_valid;
    cmb_frame_t tx_frame;
    logic [7:0] rdata;
    logic ack;
    logic tx_irq;
    logic rx_irq;
    logic rx_full;
    logic mode_ok;
  } cmb_dev_t;

  cmb_dev_t s;
  cmb_dev_t next_s;
  // storage is plain ram: no reset, contents undefined until written
  logic [7:0] tx_mem [CMB_N_TX][CMB_TX_BYTES];
  logic [7:0] rx_mem [RX_DEPTH][CMB_RX_BYTES];
  logic [7:0] rx_bg [CMB_RX_BYTES];
  logic rx_push;
  logic rx_pass;

  //////////////////////////////////////////////////////////////////////////
  // identifier packing, extended uses 32 bits, standard 13 with ide zero
  function automatic logic [31:0] pack_id(input cmb_frame_t f);
    if (f.ext) begin
      pack_id = {f.id[28:21], f.id[20:18], 1'b1, 1'b1, f.id[17:15], f.id[14:7], f.id[6:0], f.rtr};
    end else begin
      pack_id = {f.id[10:3], f.id[2:0], f.rtr, 1'b0, 3'h0, 16'h0000};
    end
  endfunction

  function automatic cmb_frame_t unpack_buf(input logic [1:0] b);
    cmb_frame_t f;
    logic [7:0] i0;
    logic [7:0] i1;
    logic [7:0] i2;
    logic [7:0] i3;
    f = '0;
    i0 = tx_mem[b][0];
    i1 = tx_mem[b][1];
    i2 = tx_mem[b][2];
    i3 = tx_mem[b][3];
    f.ext = i1[3];
    if (f.ext) begin
      f.id = {i0, i1[7:5], i1[2:0], i2, i3[7:1]};
      f.rtr = i3[0];
    end else begin
      f.id = {18'h00000, i0, i1[7:5]}; // rtr sits elsewhere in standard form
      f.rtr = i1[4];
    end
    f.dlc = tx_mem[b][MSG_DLC][3:0];
    for (int k = 0; k < 8; k++) begin
      f.data[63-8*k -: 8] = tx_mem[b][int'(MSG_DATA) + k];
    end
    unpack_buf = f;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // background buffer image of the incoming frame, 15 bytes
  always_comb begin
    logic [31:0] idw;
    idw = pack_id(rx_frame);
    for (int k = 0; k < CMB_RX_BYTES; k++) begin
      rx_bg[k] = 8'h00;
    end
    for (int k = 0; k < 4; k++) begin
      rx_bg[k] = idw[31-8*k -: 8];
    end
    for (int k = 0; k < 8; k++) begin
      rx_bg[int'(MSG_DATA) + k] = rx_frame.data[63-8*k -: 8];
    end
    rx_bg[MSG_DLC] = {4'h0, rx_frame.dlc};
    rx_bg[MSG_LOCAL_TX_PRIORITY] = rx_frame.ts[15:8];
    rx_bg[MSG_TS] = rx_frame.ts[7:0];
    // filter runs on the same bytes being stored
    rx_pass = ((idw[31:24] ^ s.fcode) & s.fmask) == 8'h00;
    rx_push = rx_valid && rx_pass && (s.cnt < 3'(RX_DEPTH));
  end

  // ram writes; tx buffer only when empty and selected
  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[s.wr_ptr] <= rx_bg;
    end
    for (int b = 0; b < CMB_N_TX; b++) begin
      if (bus.req_wr && bus.addr[7:4] == REG_MSG[7:4] && s.sel[b] && s.empty[b]) begin
        tx_mem[b][bus.addr[3:0]] <= bus.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state: software writes first, hardware events after so sets win
  always_comb begin
    logic [7:0] best;
    logic found;
    logic [1:0] pick;
    logic pop;
    logic [3:0] off;
    next_s = s;
    best = 8'hFF;
    found = 1'b0;
    pick = 2'd0;
    pop = 1'b0;
    off = bus.addr[3:0];
    next_s.ack = bus.req_rd || bus.req_wr;
    next_s.rdata = 8'h00;
    // acknowledges follow their requests one cycle later
    next_s.sleep_acknowledge = s.ctl[CTL_SLEEP_REQUEST];
    next_s.init_acknowledge = s.ctl[CTL_INIT_REQUEST];
    if (bus.req_wr) begin
      unique case (bus.addr)
        REG_CTL: next_s.ctl = bus.wdata[4:0];
        REG_MISC: if (bus.wdata[0]) next_s.hold = 1'b0; // zero ignored
        REG_RFLG: pop = bus.wdata[0] && s.cnt != 3'd0; // release foreground
        REG_TFLG: next_s.empty = s.empty & ~bus.wdata[2:0];
        REG_TARQ: next_s.arq = s.arq | (bus.wdata[2:0] & ~s.empty);
        REG_TBSEL: next_s.sel = (bus.wdata[2:0] & s.empty) & ~((bus.wdata[2:0] & s.empty) - 3'd1);
        REG_FCODE: next_s.fcode = bus.wdata;
        REG_FMASK: next_s.fmask = bus.wdata;
        default: ;
      endcase
    end
    if (bus.req_rd) begin
      unique case (bus.addr)
        REG_CTL: next_s.rdata = {1'b0, s.init_acknowledge, s.sleep_acknowledge, s.ctl};
        REG_MISC: next_s.rdata = {7'h00, s.hold};
        REG_RXERR: next_s.rdata = s.rxerr; // read-only, no write path
        REG_RFLG: next_s.rdata = {7'h00, s.cnt != 3'd0};
        REG_TFLG: next_s.rdata = {5'h00, s.empty};
        REG_TARQ: next_s.rdata = {5'h00, s.arq};
        REG_TAAK: next_s.rdata = {5'h00, s.aak};
        REG_TBSEL: next_s.rdata = {5'h00, s.sel};
        REG_FCODE: next_s.rdata = s.fcode;
        REG_FMASK: next_s.rdata = s.fmask;
        default: begin
          // only the foreground buffer is visible to software
          if (bus.addr[7:4] == REG_MSG[7:4] && off < 4'(CMB_RX_BYTES) && s.cnt != 3'd0) begin
            next_s.rdata = rx_mem[s.rd_ptr][off];
          end
        end
      endcase
    end
    // transmission outcome
    if (s.busy && tx_done) begin
      next_s.empty[s.cur] = 1'b1; // sent: release buffer
      next_s.aak[s.cur] = 1'b0; // sent reads zero
      next_s.arq[s.cur] = 1'b0;
      next_s.busy = 1'b0;
      next_s.tx_valid = 1'b0;
    end else if (s.busy && tx_error) begin
      // buffer stays pending and competes again at the next arbitration
      next_s.busy = 1'b0;
      next_s.tx_valid = 1'b0;
    end
    // aborts are granted only for buffers not on the bus
    for (int b = 0; b < CMB_N_TX; b++) begin
      if (s.arq[b] && !(s.busy && s.cur == 2'(b))) begin
        next_s.arq[b] = 1'b0;
        if (!s.empty[b]) begin
          next_s.aak[b] = 1'b1; // aborted reads one
          next_s.empty[b] = 1'b1;
        end
      end
    end
    // scheduling runs afresh at each arbitration start while no transmission is in flight
    if (arb_start && !s.busy) begin
      for (int b = 0; b < CMB_N_TX; b++) begin
        if (!next_s.empty[b] && !next_s.arq[b] && (!found || tx_mem[b][MSG_LOCAL_TX_PRIORITY] < best)) begin
          found = 1'b1;
          best = tx_mem[b][MSG_LOCAL_TX_PRIORITY]; // lowest value wins
          pick = 2'(b);
        end
      end
      if (found) begin
        next_s.busy = 1'b1;
        next_s.cur = pick;
        next_s.tx_valid = 1'b1;
        next_s.tx_frame = unpack_buf(pick);
      end
    end
    // rx fifo: head is the foreground, full flag follows occupancy
    if (rx_push) begin
      next_s.wr_ptr = (s.wr_ptr == 3'(RX_DEPTH - 1)) ? 3'd0 : s.wr_ptr + 3'd1;
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == 3'(RX_DEPTH - 1)) ? 3'd0 : s.rd_ptr + 3'd1;
    end
    next_s.cnt = s.cnt + 3'(rx_push) - 3'(pop);
    // error count: up on error, down on good frame, saturating
    if (rx_error && s.rxerr != RXERR_MAX) begin
      next_s.rxerr = s.rxerr + 8'd1;
    end else if (rx_valid && !rx_error && s.rxerr != 8'h00) begin
      next_s.rxerr = s.rxerr - 8'd1;
    end
    // bus-off hold only under recovery-on-request; set beats the clear
    if (busoff_enter && s.ctl[CTL_BUSOFF_RECOVERY_SELECT]) begin
      next_s.hold = 1'b1;
    end
    // interrupt levels gated by the enables; polling sees the flags anyway
    next_s.tx_irq = s.ctl[CTL_TXIE] && (next_s.empty != 3'h0);
    next_s.rx_irq = s.ctl[CTL_RXIE] && (next_s.cnt != 3'd0);
    next_s.rx_full = next_s.cnt != 3'd0;
    next_s.mode_ok = (next_s.ctl[CTL_SLEEP_REQUEST] && next_s.sleep_acknowledge) || (next_s.ctl[CTL_INIT_REQUEST] && next_s.init_acknowledge);
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.ctl <= CTL_RST;
      s.empty <= TFLG_RST;
    end else begin
      s <= next_s;
    end
  end

  assign bus.rdata = s.rdata;
  assign bus.ack = s.ack;
  assign bus.st_tx_empty = s.empty;
  assign bus.st_tx_sel = s.sel;
  assign bus.st_rx_full = s.rx_full;
  assign bus.st_mode_ok = s.mode_ok;
  assign tx_valid = s.tx_valid;
  assign tx_frame = s.tx_frame;
  assign busoff_hold = s.hold; // engine stays bus-off while high
  assign tx_irq = s.tx_irq;
  assign rx_irq = s.rx_irq;
endmodule
`default_nettype wire

// ==== src/cmb_pkg.sv ====
// constants and types shared by both ends of the can message buffering block
// assumes one 25 MHz clock, synchronous active-high reset, 8-bit register path
// Function
// - bus-off hold flag set, held until cleared
// - hold flag readable; write one clears it
// - rx error count read only in sleep/init
// - message storage is ram, not reset
// - tx buffer written only empty and selected
// - foreground read only while rx full set
// - extended id stored as 32 bits
// - standard id 13 bits, ide zero
// - sent buffer sets empty, raises tx interrupt
// - lowest priority value transmits first
// - reprioritise at every arbitration, errors too
// - abort idle buffer: ack, empty, interrupt
// - abort ack one if aborted, zero sent
// - five-stage rx fifo, cpu sees foreground
// - each rx buffer is fifteen bytes
// - rx full when foreground holds accepted frame
// - filter checked while frame stored
// - valid frame moves in, sets full, interrupt
// - software reads frame then clears full
`default_nettype none
package cmb_pkg;
  localparam int CMB_N_TX = 3;
  localparam int CMB_RX_DEPTH = 5;
  localparam int CMB_RX_BYTES = 15;
  localparam int CMB_TX_BYTES = 16;
  // register offsets on the device path, and the bridge status address
  localparam logic [7:0] REG_CTL = 8'h00;
  localparam logic [7:0] REG_MISC = 8'h01;
  localparam logic [7:0] REG_RXERR = 8'h02;
  localparam logic [7:0] REG_RFLG = 8'h03;
  localparam logic [7:0] REG_TFLG = 8'h04;
  localparam logic [7:0] REG_TARQ = 8'h05;
  localparam logic [7:0] REG_TAAK = 8'h06;
  localparam logic [7:0] REG_TBSEL = 8'h07;
  localparam logic [7:0] REG_FCODE = 8'h08;
  localparam logic [7:0] REG_FMASK = 8'h09;
  localparam logic [7:0] REG_MSG = 8'h10;
  localparam logic [5:0] REG_HOST_STAT = 6'h20;
  // control register bit positions
  localparam int CTL_BUSOFF_RECOVERY_SELECT = 0;
  localparam int CTL_SLEEP_REQUEST = 1;
  localparam int CTL_INIT_REQUEST = 2;
  localparam int CTL_TXIE = 3;
  localparam int CTL_RXIE = 4;
  localparam int CTL_SLEEP_ACKNOWLEDGE = 5;
  localparam int CTL_INIT_ACKNOWLEDGE = 6;
  // message buffer byte offsets
  localparam logic [3:0] MSG_DATA = 4'h4;
  localparam logic [3:0] MSG_DLC = 4'hC;
  localparam logic [3:0] MSG_LOCAL_TX_PRIORITY = 4'hD;
  localparam logic [3:0] MSG_TS = 4'hE;
  // values after reset, and the error count ceiling
  localparam logic [4:0] CTL_RST = 5'h00;
  localparam logic [2:0] TFLG_RST = 3'h7;
  localparam logic [7:0] RXERR_MAX = 8'hFF;
  typedef struct packed {
    logic ext;
    logic [28:0] id;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
    logic [15:0] ts;
  } cmb_frame_t;
endpackage
`default_nettype wire

// ==== src/cmb_if.sv ====
// register path between the command bridge and the buffering device
// assumes both ends run on clk; strobes are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface cmb_if (input wire logic clk);
  logic req_rd;
  logic req_wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic [2:0] st_tx_empty;
  logic [2:0] st_tx_sel;
  logic st_rx_full;
  logic st_mode_ok;
  modport dev (input req_rd, req_wr, addr, wdata,
    output rdata, ack, st_tx_empty, st_tx_sel, st_rx_full, st_mode_ok);
  modport host (output req_rd, req_wr, addr, wdata,
    input rdata, ack, st_tx_empty, st_tx_sel, st_rx_full, st_mode_ok);
endinterface
`default_nettype wire

// ==== src/cmb_host.sv ====
// command bridge: avalon-mm slave for software, master of the device path
// assumes the device answers every strobe with ack one cycle later
`timescale 1ns/1ns
`default_nettype none
module cmb_host
  import cmb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  cmb_if.host bus
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WAIT = 2'b01,
    HS_DONE = 2'b10
  } cmb_hstate_t;

  typedef struct packed {
    cmb_hstate_t st;
    logic wreq;
    logic [31:0] rdata;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic refused;
  } cmb_host_t;

  cmb_host_t s;
  cmb_host_t next_s;

  //////////////////////////////////////////////////////////////////////////
  // accesses that break the device's access rules are refused here
  always_comb begin
    logic msg;
    logic bad;
    next_s = s;
    msg = avs_address[4];
    bad = 1'b0;
    next_s.rd = 1'b0;
    next_s.wr = 1'b0;
    unique case (s.st)
      HS_IDLE: begin
        if (avs_read || avs_write) begin
          if (avs_address[5]) begin
            // bridge status: sticky refusal flag, write one clears
            next_s.rdata = {31'h0, s.refused};
            if (avs_write && avs_writedata[0]) next_s.refused = 1'b0;
            next_s.wreq = 1'b0;
            next_s.st = HS_DONE;
          end else begin
            if (avs_read && avs_address == REG_RXERR[5:0] && !bus.st_mode_ok) bad = 1'b1;
            if (avs_write && avs_address == REG_RXERR[5:0]) bad = 1'b1;
            if (avs_write && msg && (bus.st_tx_sel & bus.st_tx_empty) == 3'h0) bad = 1'b1;
            if (avs_read && msg && !bus.st_rx_full) bad = 1'b1;
            if (bad) begin
              next_s.refused = 1'b1;
              next_s.rdata = 32'h0;
              next_s.wreq = 1'b0;
              next_s.st = HS_DONE;
            end else begin
              next_s.rd = avs_read;
              next_s.wr = avs_write;
              next_s.addr = {2'b00, avs_address};
              next_s.wdata = avs_writedata[7:0];
              next_s.st = HS_WAIT;
            end
          end
        end
      end
      HS_WAIT: begin
        if (bus.ack) begin
          next_s.rdata = {24'h0, bus.rdata};
          next_s.wreq = 1'b0;
          next_s.st = HS_DONE;
        end
      end
      HS_DONE: begin
        // one cycle of waitrequest low, then back to idle
        next_s.wreq = 1'b1;
        next_s.st = HS_IDLE;
      end
      default: begin
        next_s.wreq = 1'b1;
        next_s.st = HS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.st <= HS_IDLE;
      s.wreq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign bus.req_rd = s.rd;
  assign bus.req_wr = s.wr;
  assign bus.addr = s.addr;
  assign bus.wdata = s.wdata;
endmodule
`default_nettype wire

// ==== tb/cmb_monitor.sv ====
// checker on the register path between the bridge and the device
// assumes one clock and srst synchronous, active high
`timescale 1ns/1ns
`default_nettype none
module cmb_monitor
  import cmb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req_rd,
  input wire logic req_wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic [2:0] st_tx_empty,
  input wire logic [2:0] st_tx_sel,
  input wire logic st_rx_full,
  input wire logic st_mode_ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [2:0] sel_cand;
  logic [2:0] sel_low;
  ////////////////////////////////////////////////////////////////
  // lowest empty buffer a select write may keep
  assign sel_cand = wdata[2:0] & st_tx_empty;
  assign sel_low = sel_cand & (~sel_cand + 3'h1);
  ////////////////////////////////////////////////////////////////
  // every strobe gets exactly one ack, one cycle later
  AST_ACK_ONE_CYCLE: assert property ((req_rd || req_wr) |=> ack)
    else $error("request not acknowledged");
  AST_ACK_CAUSED: assert property (ack |-> $past(req_rd || req_wr))
    else $error("ack without request");
  // gated accesses never reach the device
  AST_RXERR_MODE: assert property (req_rd && addr == REG_RXERR |-> st_mode_ok)
    else $error("error count read outside sleep or init");
  AST_RXERR_RO: assert property (req_wr |-> addr != REG_RXERR)
    else $error("write reached error count");
  AST_TXWIN_WRITE: assert property (req_wr && addr[7:4] == 4'h1 |-> (st_tx_empty & st_tx_sel) != 3'h0)
    else $error("tx window written while not empty and selected");
  AST_RXWIN_READ: assert property (req_rd && addr[7:4] == 4'h1 |-> st_rx_full)
    else $error("rx window read while not full");
  // select keeps only the lowest empty buffer named
  AST_SEL_LOW: assert property (req_wr && addr == REG_TBSEL |=> st_tx_sel == $past(sel_low))
    else $error("select not lowest empty bit");
  AST_SEL_ONEHOT: assert property ($onehot0(st_tx_sel))
    else $error("more than one buffer selected");
  ////////////////////////////////////////////////////////////////
  // main scenarios reached
  COV_RXERR: cover property (req_rd && addr == REG_RXERR);
  COV_RXWIN: cover property (req_rd && addr[7:4] == 4'h1);
  COV_TXWIN: cover property (req_wr && addr[7:4] == 4'h1);
endmodule
`default_nettype wire

// ==== tb/cmb_tb_top.sv ====
// self-checking bench: bridge and device joined over the register path
// assumes the bench stands in for the protocol engine on the link strobes
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module cmb_tb_top
  import cmb_pkg::*;
;
  localparam int DEPTH = 5;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic arb_start = 1'b0, tx_done = 1'b0, tx_error = 1'b0;
  logic rx_valid = 1'b0, rx_error = 1'b0, busoff_enter = 1'b0;
  logic tx_valid, busoff_hold, tx_irq, rx_irq;
  cmb_frame_t rx_frame = '0;
  cmb_frame_t tx_frame;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int rxerr = 0;
  logic [31:0] seed = 32'h3062FB21;
  logic [7:0] rd;
  logic [7:0] local_tx_priority [3];
  cmb_frame_t rxq [$];
  ////////////////////////////////////////////////////////////////
  // both ends face each other; the checker watches the path
  cmb_if cif (.clk(clk));
  cmb_device #(.RX_DEPTH(DEPTH)) cmb_device_inst (.clk(clk), .srst(srst), .bus(cif), .arb_start(arb_start),
    .tx_done(tx_done), .tx_error(tx_error), .tx_valid(tx_valid), .tx_frame(tx_frame), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .rx_error(rx_error), .busoff_enter(busoff_enter), .busoff_hold(busoff_hold),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  cmb_host cmb_host_inst (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus(cif));
  cmb_monitor cmb_monitor_inst (.clk(clk), .srst(srst), .req_rd(cif.req_rd), .req_wr(cif.req_wr),
    .addr(cif.addr), .wdata(cif.wdata), .rdata(cif.rdata), .ack(cif.ack), .st_tx_empty(cif.st_tx_empty),
    .st_tx_sel(cif.st_tx_sel), .st_rx_full(cif.st_rx_full), .st_mode_ok(cif.st_mode_ok));
  ////////////////////////////////////////////////////////////////
  // clock and hang guard, the run needs a few hundred cycles
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // one avalon transfer, request held until waitrequest is seen low; only the run timeout ends a hang
  task automatic av(input logic w, input logic [5:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= ~w;
    avs_write <= w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    `CHK(avs_readdata[31:8], 24'h000000)
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    av(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  // error count only readable in sleep or init mode, so enter one briefly
  task automatic rd_err(input logic [7:0] m);
    av(1'b1, REG_CTL[5:0], m);
    rchk(REG_RXERR[5:0], 8'(rxerr));
    av(1'b1, REG_CTL[5:0], 8'h18);
  endtask
  // one-cycle link strobe, then settle time for its effect
  task automatic pulse(input int k);
    case (k)
      0: arb_start <= 1'b1;
      1: tx_done <= 1'b1;
      2: tx_error <= 1'b1;
      3: rx_valid <= 1'b1;
      4: rx_error <= 1'b1;
      default: busoff_enter <= 1'b1;
    endcase
    @(posedge clk);
    {arb_start, tx_done, tx_error, rx_valid, rx_error, busoff_enter} <= 6'h00;
    repeat (2) @(posedge clk);
  endtask
  // lowest priority value wins, ties go to the lower index
  function automatic int pick(input logic [2:0] pend);
    int b = -1;
    for (int i = 0; i < 3; i++)
      if (pend[i] && (b < 0 || local_tx_priority[i] < local_tx_priority[b])) b = i;
    return b;
  endfunction
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int b;
    logic [2:0] pend;
    logic [7:0] v;
    cmb_frame_t f;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rchk(REG_CTL[5:0], 8'h00);
    rchk(REG_TFLG[5:0], 8'h07);
    av(1'b1, REG_CTL[5:0], 8'h19);
    pulse(5);
    av(1'b1, REG_MISC[5:0], 8'h00);
    rchk(REG_MISC[5:0], 8'h01);
    `CHK(busoff_hold, 1'b1)
    av(1'b1, REG_MISC[5:0], 8'h01);
    rchk(REG_MISC[5:0], 8'h00);
    av(1'b1, REG_CTL[5:0], 8'h18);
    pulse(5);
    `CHK(busoff_hold, 1'b0)
    repeat (3) pulse(4);
    rxerr = 3;
    rchk(REG_RXERR[5:0], 8'h00);
    av(1'b0, REG_HOST_STAT, 8'h00);
    `CHK(rd[0], 1'b1)
    av(1'b1, REG_RXERR[5:0], 8'h55);
    rd_err(8'h1A);
    // fill three tx buffers, dlc marks which one goes out
    for (int i = 0; i < 3; i++) begin
      local_tx_priority[i] = rnd();
      av(1'b1, REG_TBSEL[5:0], 8'(1 << i));
      av(1'b1, 6'h1C, 8'(i + 1));
      av(1'b1, 6'h1D, local_tx_priority[i]);
    end
    av(1'b1, REG_TFLG[5:0], 8'h04);
    pulse(0);
    `CHK(tx_frame.dlc, 4'h3)
    pulse(2);
    av(1'b1, REG_TFLG[5:0], 8'h03);
    pend = 3'h7;
    `CHK(tx_irq, 1'b0)
    for (int k = 0; k < 3; k++) begin
      b = pick(pend);
      pulse(0);
      `CHK(tx_frame.dlc, 4'(b + 1))
      pulse(1);
      pend[b] = 1'b0;
      rchk(REG_TFLG[5:0], {5'h00, ~pend});
      `CHK(tx_irq, 1'b1)
    end
    // abort all while the best one is in flight
    av(1'b1, REG_TFLG[5:0], 8'h07);
    b = pick(3'h7);
    pulse(0);
    av(1'b1, REG_TARQ[5:0], 8'h07);
    v = 8'h07 ^ (8'h01 << b);
    rchk(REG_TAAK[5:0], v);
    rchk(REG_TFLG[5:0], v);
    `CHK(tx_valid, 1'b1)
    pulse(1);
    rchk(REG_TAAK[5:0], v);
    rchk(REG_TFLG[5:0], 8'h07);
    // receive: one frame filtered out, one in standard form, one dropped on a full fifo
    av(1'b1, REG_FCODE[5:0], 8'hA5);
    av(1'b1, REG_FMASK[5:0], 8'hFF);
    for (int j = 0; j < DEPTH + 2; j++) begin
      v = rnd();
      f = '0;
      f.ext = (j != 3);
      f.rtr = v[4];
      f.id = f.ext ? {(j == 1) ? 8'h5A : 8'hA5, 13'h0000, v} : {18'h00000, 8'hA5, v[2:0]};
      f.dlc = v[3:0];
      f.ts = {v, ~v};
      f.data = {8{v}};
      rx_frame <= f;
      pulse(3);
      if (rxerr > 0) rxerr--;
      if (j != 1 && rxq.size() < DEPTH) rxq.push_back(f);
    end
    `CHK(rx_irq, 1'b1)
    rd_err(8'h1C);
    while (rxq.size() > 0) begin
      f = rxq.pop_front();
      av(1'b0, REG_RFLG[5:0], 8'h00);
      `CHK(rd[0], 1'b1)
      rchk(6'h10, f.ext ? f.id[28:21] : f.id[10:3]);
      rchk(6'h11, f.ext ? {f.id[20:18], 2'b11, f.id[17:15]} : {f.id[2:0], f.rtr, 4'h0});
      av(1'b0, 6'h1C, 8'h00);
      `CHK(rd[3:0], f.dlc)
      rchk(6'h1D, f.ts[15:8]);
      rchk(6'h1E, f.ts[7:0]);
      av(1'b1, REG_RFLG[5:0], 8'h01);
    end
    av(1'b0, REG_RFLG[5:0], 8'h00);
    `CHK(rd[0], 1'b0)
    `CHK(rx_irq, 1'b0)
    rchk(6'h10, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
